// ==== scx_context_top.sv ====
// Context switch configuration block: register banks, staging, bus slave
`timescale 1ns/1ns
module scx_context_top
  import scx_pkg::*;
#(
  parameter int VARIANT = scx_pkg::VAR_COLOUR
)(
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        SYS_RST,
  // Wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [11:0] WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // Frame timing from readout core
  input  wire logic        FRAME_START,
  // Active set indication
  output logic             ACTIVE_EXP_SET,
  output logic             ACTIVE_SET,
  // Exposure and timing
  output logic      [15:0] EXP_ROWS,
  output logic      [15:0] EXP_ROWS_SECOND,
  output logic      [15:0] LINE_LENGTH,
  output logic      [15:0] FRAME_LENGTH,
  // Window
  output logic      [15:0] X_START,
  output logic      [15:0] X_END,
  output logic      [15:0] Y_START,
  output logic      [15:0] Y_END,
  // Pixel overrides
  output logic      [15:0] CG_OVERRIDE,
  output logic      [15:0] CG_OVERRIDE_T1,
  output logic             PIX_COMB_BYPASS,
  // Gains
  output logic      [6:0]  ANALOG_GAIN,
  output logic      [6:0]  ANALOG_GAIN_T1,
  output logic      [15:0] DGAIN_R,
  output logic      [15:0] DGAIN_GR,
  output logic      [15:0] DGAIN_GB,
  output logic      [15:0] DGAIN_B,
  output logic      [15:0] GLOBAL_GAIN,
  // Subsampling and mode
  output logic             H_BIN,
  output logic             V_BIN,
  output logic             V_SUM,
  output logic             X_SKIP,
  output logic             Y_SKIP,
  output logic      [15:0] ROWS_OUT,
  output logic             HDR_INTERLEAVE
);

  if (VARIANT < VAR_COLOUR || VARIANT > VAR_RGBIR)
    $error("scx_context_top: VARIANT out of range");

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    scx_wb_e                     wb;
    logic                        ack;
    logic [31:0]                 dat;
    logic                        sel;
    logic                        exp_set;
    logic                        oth_set;
    logic [15:0]                 fcnt;
    logic [1:0][NSET-1:0][15:0]  bank;
    logic [NSET-1:0][15:0]       act;
  } scx_state_s;

  scx_state_s st_reg;
  scx_state_s st_next;

  logic        mem_we;
  logic [15:0] mem_rdata;

  function automatic scx_state_s state_rst();
    scx_state_s s;
    s = '0;
    for (int i = 0; i < NSET; i++)
    begin
      s.bank[0][i] = setting_rst(i);
      s.bank[1][i] = setting_rst(i);
      s.act[i]     = setting_rst(i);
    end
    return s;
  endfunction : state_rst

  // Bank hit: returns set number in bit 5, index below; bit 6 = valid
  function automatic logic [6:0] bank_hit(input logic [11:0] a);
    logic [4:0] idx;
    idx = a[6:2];
    if (a[11:7] == A_BANKA[11:7] && 32'(idx) < NSET)
      return {1'b1, 1'b0, idx};
    if (a[11:7] == A_BANKB[11:7] && 32'(idx) < NSET)
      return {1'b1, 1'b1, idx};
    return 7'h00;
  endfunction : bank_hit

  function automatic logic is_exposure(input int i);
    return i == S_EXP_ROWS || i == S_EXP_ROWS_SECOND;
  endfunction : is_exposure

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    logic [6:0] hit;
    logic       acc;
    logic       is_mem;
    hit     = bank_hit(WB_ADR_I);
    acc     = WB_CYC_I && WB_STB_I && !st_reg.ack;
    is_mem  = WB_ADR_I[11:10] == A_CTXM[11:10];
    st_next = st_reg;
    st_next.ack = 1'b0;
    mem_we  = 1'b0;
    unique case (st_reg.wb)
      WB_IDLE:
      begin
        if (acc && is_mem)
        begin
          if (WB_WE_I)
          begin
            mem_we      = 1'b1;
            st_next.ack = 1'b1;
          end
          else
          begin
            st_next.wb = WB_MEMRD;
          end
        end
        else if (acc)
        begin
          st_next.ack = 1'b1;
          st_next.dat = 32'h0000_0000;
          if (WB_ADR_I == A_CTRL)
          begin
            st_next.dat[CTRL_SEL] = st_reg.sel;
            if (WB_WE_I && WB_SEL_I[0])
              st_next.sel = WB_DAT_I[CTRL_SEL];
          end
          else if (WB_ADR_I == A_STAT)
          begin
            st_next.dat[ST_EXP_SET] = st_reg.exp_set;
            st_next.dat[ST_OTH_SET] = st_reg.oth_set;
            st_next.dat[ST_FCNT_LSB+:16] = st_reg.fcnt;
          end
          else if (hit[6])
          begin
            st_next.dat[15:0] = st_reg.bank[hit[5]][hit[4:0]];
            if (WB_WE_I && WB_SEL_I[0])
              st_next.bank[hit[5]][hit[4:0]][7:0] = WB_DAT_I[7:0];
            if (WB_WE_I && WB_SEL_I[1])
              st_next.bank[hit[5]][hit[4:0]][15:8] = WB_DAT_I[15:8];
          end
        end
      end
      WB_MEMRD:
      begin
        st_next.wb  = WB_IDLE;
        st_next.ack = 1'b1;
        st_next.dat = {16'h0000, mem_rdata};
      end
    endcase

    // Frame boundary: exposure follows select one frame on, the rest
    // follows the exposure set one frame later still
    if (FRAME_START)
    begin
      st_next.exp_set = st_reg.sel;
      st_next.oth_set = st_reg.exp_set;
      st_next.fcnt    = 16'(st_reg.fcnt + 16'h0001);
      for (int i = 0; i < NSET; i++)
      begin
        if (is_exposure(i))
          st_next.act[i] = st_reg.bank[st_reg.sel][i];
        else
          st_next.act[i] = st_reg.bank[st_reg.exp_set][i];
      end
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST) st_reg <= state_rst();
    else         st_reg <= st_next;
  end

  // ************************************************************
  // Context memory and readout controls
  // ************************************************************
  scx_ctx_mem #(
    .DEPTH (CTX_DEPTH),
    .WIDTH (CTX_W)
  ) u_mem (
    .clk   (REF_CLK),
    .we    (mem_we),
    .be    (WB_SEL_I[1:0]),
    .addr  (WB_ADR_I[9:2]),
    .wdata (WB_DAT_I[15:0]),
    .rdata (mem_rdata)
  );

  scx_readout #(
    .VARIANT (VARIANT)
  ) u_ro (
    .clk       (REF_CLK),
    .rst       (SYS_RST),
    .act       (st_reg.act),
    .ag        (ANALOG_GAIN),
    .ag_t1     (ANALOG_GAIN_T1),
    .dg_r      (DGAIN_R),
    .dg_gr     (DGAIN_GR),
    .dg_gb     (DGAIN_GB),
    .dg_b      (DGAIN_B),
    .dg_global (GLOBAL_GAIN),
    .h_bin     (H_BIN),
    .v_bin     (V_BIN),
    .v_sum     (V_SUM),
    .x_skip    (X_SKIP),
    .y_skip    (Y_SKIP),
    .rows_out  (ROWS_OUT),
    .hdr_il    (HDR_INTERLEAVE)
  );

  // ************************************************************
  // Outputs
  // ************************************************************
  assign WB_DAT_O        = st_reg.dat;
  assign WB_ACK_O        = st_reg.ack;
  assign ACTIVE_EXP_SET  = st_reg.exp_set;
  assign ACTIVE_SET      = st_reg.oth_set;
  assign EXP_ROWS        = st_reg.act[S_EXP_ROWS];
  assign EXP_ROWS_SECOND = st_reg.act[S_EXP_ROWS_SECOND];
  assign LINE_LENGTH     = st_reg.act[S_LINE_LEN];
  assign FRAME_LENGTH    = st_reg.act[S_FRAME_LEN];
  assign X_START         = st_reg.act[S_X_START];
  assign X_END           = st_reg.act[S_X_END];
  assign Y_START         = st_reg.act[S_Y_START];
  assign Y_END           = st_reg.act[S_Y_END];
  assign CG_OVERRIDE     = st_reg.act[S_CG_OVR];
  assign CG_OVERRIDE_T1  = st_reg.act[S_CG_OVR_T1];
  assign PIX_COMB_BYPASS = st_reg.act[S_PIX_COMB_BYP][0];

endmodule : scx_context_top

// ==== scx_context_top_properties.sv ====
// Port checker for the context switch configuration block
`timescale 1ns/1ns
module scx_context_top_chk (
  // Clock and reset
  input wire logic        REF_CLK,
  input wire logic        SYS_RST,
  // Register bus
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [11:0] WB_ADR_I,
  input wire logic        WB_ACK_O,
  // Frame staging and outputs
  input wire logic        FRAME_START,
  input wire logic        ACTIVE_EXP_SET,
  input wire logic        ACTIVE_SET,
  input wire logic [15:0] EXP_ROWS,
  input wire logic [15:0] LINE_LENGTH,
  input wire logic [6:0]  ANALOG_GAIN,
  input wire logic [15:0] DGAIN_R,
  input wire logic [15:0] Y_START,
  input wire logic [15:0] Y_END,
  input wire logic        Y_SKIP,
  input wire logic [15:0] ROWS_OUT
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  ack_one_cycle_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  reg_ack_time_a: assert property ($rose(WB_STB_I) && WB_CYC_I
    && (WB_WE_I || WB_ADR_I[11:10] != 2'b01) |=> WB_ACK_O)
    else $error("register access not acked after one cycle");
  mem_read_wait_a: assert property ($rose(WB_STB_I) && WB_CYC_I
    && !WB_WE_I && WB_ADR_I[11:10] == 2'b01 |=> !WB_ACK_O ##1 WB_ACK_O)
    else $error("memory read not acked after two cycles");
  other_set_lag_a: assert property (FRAME_START
    |=> ACTIVE_SET == $past(ACTIVE_EXP_SET))
    else $error("other settings set did not trail exposure set");
  frame_hold_a: assert property (!FRAME_START |=>
    $stable(ACTIVE_EXP_SET) && $stable(ACTIVE_SET)
    && $stable(EXP_ROWS) && $stable(LINE_LENGTH))
    else $error("active settings moved between frames");
  again_cap_a: assert property (ANALOG_GAIN <= 7'h40)
    else $error("analog gain above x16");
  dgain_range_a: assert property (!$past(SYS_RST)
    && !$past(SYS_RST, 2) && !$past(SYS_RST, 3)
    |-> DGAIN_R >= 16'h0080 && DGAIN_R <= 16'h0800)
    else $error("digital gain outside unity to x16");
  rows_calc_a: assert property (!$past(FRAME_START)
    && !$past(SYS_RST) && !$past(SYS_RST, 2) && !$past(SYS_RST, 3)
    |-> ROWS_OUT == ((Y_END - Y_START + 16'h0001) >> Y_SKIP))
    else $error("row count does not follow window and skip");
endmodule : scx_context_top_chk

bind scx_context_top scx_context_top_chk u_chk (
  .REF_CLK, .SYS_RST, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I,
  .WB_ACK_O, .FRAME_START, .ACTIVE_EXP_SET, .ACTIVE_SET, .EXP_ROWS,
  .LINE_LENGTH, .ANALOG_GAIN, .DGAIN_R, .Y_START, .Y_END, .Y_SKIP,
  .ROWS_OUT
);

// ==== scx_context_top_tb_top.sv ====
// Self-checking testbench for the context switch block
`timescale 1ns/1ns
module scx_context_top_tb_top;
  import scx_pkg::*;
  logic        REF_CLK = 1'b0;
  logic        SYS_RST = 1'b1;
  logic        WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, FRAME_START;
  logic [11:0] WB_ADR_I;
  logic [3:0]  WB_SEL_I;
  logic [31:0] WB_DAT_I, WB_DAT_O, q;
  logic        ACTIVE_EXP_SET, ACTIVE_SET, H_BIN, V_BIN, V_SUM, Y_SKIP;
  logic        HDR_INTERLEAVE;
  logic [15:0] EXP_ROWS, LINE_LENGTH, DGAIN_R, ROWS_OUT;
  logic [6:0]  ANALOG_GAIN, ANALOG_GAIN_T1;
  logic [15:0] EXP_ROWS_SECOND, FRAME_LENGTH, X_START, X_END, Y_START;
  logic [15:0] Y_END, CG_OVERRIDE, CG_OVERRIDE_T1, DGAIN_GR, DGAIN_GB;
  logic [15:0] DGAIN_B, GLOBAL_GAIN;
  logic        PIX_COMB_BYPASS, X_SKIP;
  int          num_errors = 0;
  int          num_checks = 0;

  always #50 REF_CLK = ~REF_CLK;

  scx_context_top DUT (
    .REF_CLK, .SYS_RST, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I,
    .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .FRAME_START,
    .ACTIVE_EXP_SET, .ACTIVE_SET, .EXP_ROWS, .EXP_ROWS_SECOND,
    .LINE_LENGTH, .FRAME_LENGTH, .X_START, .X_END, .Y_START,
    .Y_END, .CG_OVERRIDE, .CG_OVERRIDE_T1, .PIX_COMB_BYPASS,
    .ANALOG_GAIN, .ANALOG_GAIN_T1, .DGAIN_R, .DGAIN_GR, .DGAIN_GB,
    .DGAIN_B, .GLOBAL_GAIN, .H_BIN, .V_BIN, .V_SUM, .X_SKIP,
    .Y_SKIP, .ROWS_OUT, .HDR_INTERLEAVE
  );

  scx_host_model u_host (
    .clk(REF_CLK), .cyc(WB_CYC_I), .stb(WB_STB_I), .we(WB_WE_I),
    .adr(WB_ADR_I), .sel(WB_SEL_I), .dat_w(WB_DAT_I), .dat_r(WB_DAT_O),
    .ack(WB_ACK_O), .frame(FRAME_START)
  );

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [11:0] sa(input logic b, input int i);
    return (b ? A_BANKB : A_BANKA) + 12'(4 * i);
  endfunction : sa

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] r;
    u_host.xfer(1'b1, a, {16'h0000, d}, 4'h3, r);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    u_host.xfer(1'b0, a, 32'h0000_0000, 4'h3, r);
  endtask : rd

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict

  // ************************************************************
  // Tests
  // ************************************************************
  initial
  begin
    repeat (8) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    rd(A_CTRL, q); chk(q, 32'h0);
    rd(sa(0, S_LINE_LEN), q); chk(q, 32'(RST_LINE_LEN));
    rd(sa(1, S_FRAME_LEN), q); chk(q, 32'(RST_FRAME_LEN));
    wr(12'h008, 16'hffff);
    rd(12'h008, q); chk(q, 32'h0);
    chk(32'(LINE_LENGTH), 32'(RST_LINE_LEN));
    chk(32'(DGAIN_R), 32'(DG_UNITY));
    chk(32'(EXP_ROWS_SECOND), 32'(RST_EXP_ROWS));
    chk(32'(FRAME_LENGTH), 32'(RST_FRAME_LEN));
    chk({X_START, X_END}, {16'h0000, RST_X_END});
    chk({Y_START, Y_END}, {16'h0000, RST_Y_END});
    chk({CG_OVERRIDE, CG_OVERRIDE_T1}, 32'h0);
    chk(32'({PIX_COMB_BYPASS, X_SKIP}), 32'h0);
    chk({DGAIN_GR, DGAIN_GB}, {DG_UNITY, DG_UNITY});
    chk({DGAIN_B, GLOBAL_GAIN}, {DG_UNITY, DG_UNITY});
    $display("reset values test done");
    wr(A_CTXM, 16'h1234);
    wr(A_CTXM + 12'h3fc, 16'hbeef);
    u_host.xfer(1'b1, A_CTXM + 12'h3fc, 32'h0000_5500, 4'h2, q);
    rd(A_CTXM + 12'h3fc, q); chk(q, 32'h0000_55ef);
    rd(A_CTXM, q); chk(q, 32'h0000_1234);
    $display("context memory test done");
    wr(sa(1, S_EXP_ROWS), 16'h0020);
    wr(sa(1, S_LINE_LEN), 16'h0500);
    wr(sa(1, S_COARSE_GAIN), 16'h0004);
    wr(A_CTRL, 16'h0001);
    chk(32'(EXP_ROWS), 32'h0010);
    u_host.pulse_frame();
    chk(32'({ACTIVE_EXP_SET, ACTIVE_SET}), 32'h2);
    chk(32'(EXP_ROWS), 32'h0020);
    chk(32'(LINE_LENGTH), 32'h0400);
    u_host.pulse_frame();
    chk(32'(ACTIVE_SET), 32'h1);
    chk(32'(LINE_LENGTH), 32'h0500);
    chk(32'(ANALOG_GAIN), 32'h40);
    rd(A_STAT, q); chk(q, 32'h0002_0003);
    $display("switch to B test done");
    wr(A_CTRL, 16'h0000);
    wr(sa(0, S_LINE_LEN), 16'h0700);
    u_host.pulse_frame();
    chk(32'(EXP_ROWS), 32'h0010);
    chk(32'(LINE_LENGTH), 32'h0500);
    u_host.pulse_frame();
    chk(32'(ACTIVE_SET), 32'h0);
    chk(32'(LINE_LENGTH), 32'h0700);
    $display("switch to A test done");
    wr(sa(0, S_GAIN_R), 16'h1000);
    wr(sa(0, S_GAIN_GR), 16'h1000);
    wr(sa(0, S_GAIN_GB), 16'h1000);
    wr(sa(0, S_GAIN_B), 16'h1000);
    wr(sa(0, S_Y_ODD_INC), SKIP2_INC);
    wr(sa(0, S_OP_MODE), 16'h0001);
    wr(sa(0, S_COARSE_GAIN_T1), 16'h0002);
    wr(sa(0, S_FINE_GAIN_T1), 16'h0005);
    wr(sa(0, S_COL_BIN), 16'h0001);
    wr(sa(0, S_ROW_BIN), 16'h0003);
    u_host.pulse_frame();
    chk(32'(DGAIN_R), 32'(DG_MAX));
    chk({DGAIN_GR, DGAIN_B}, {DG_MAX, DG_MAX});
    chk(32'(DGAIN_GB), 32'(DG_MAX));
    chk(32'({Y_SKIP, ROWS_OUT}), 32'h1_0220);
    chk(32'(ANALOG_GAIN_T1), 32'h25);
    chk(32'(HDR_INTERLEAVE), 32'h1);
    chk(32'(H_BIN), 32'h1);
    chk(32'({V_BIN, V_SUM}), 32'h2);
    $display("readout settings test done");
    give_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge REF_CLK);
    num_errors++;
    $display("CHECK FAILED at %0t: run hung", $time);
    give_verdict();
  end
endmodule : scx_context_top_tb_top

// ==== scx_ctx_mem.sv ====
// Context memory: single port, byte lanes, registered read data
`timescale 1ns/1ns
module scx_ctx_mem
  import scx_pkg::*;
#(
  parameter int DEPTH = CTX_DEPTH,
  parameter int WIDTH = CTX_W
)(
  // Clock
  input  wire logic                     clk,
  // Access
  input  wire logic                     we,
  input  wire logic [1:0]               be,
  input  wire logic [$clog2(DEPTH)-1:0] addr,
  input  wire logic [WIDTH-1:0]         wdata,
  output logic      [WIDTH-1:0]         rdata
);

  if (WIDTH != 16) $error("scx_ctx_mem: WIDTH must be 16");
  if (DEPTH < 2)   $error("scx_ctx_mem: DEPTH too small");

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk)
  begin
    if (we && be[0]) mem[addr][7:0] <= wdata[7:0];
    if (we && be[1]) mem[addr][15:8] <= wdata[15:8];
    rdata <= mem[addr];
  end

endmodule : scx_ctx_mem

// ==== scx_host_model.sv ====
// Host model: register bus master and frame timing source
`timescale 1ns/1ns
module scx_host_model (
  // Clock
  input  wire logic        clk,
  // Bus master
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [11:0]      adr,
  output logic [3:0]       sel,
  output logic [31:0]      dat_w,
  input  wire logic [31:0] dat_r,
  input  wire logic        ack,
  // Frame timing
  output logic             frame
);
  initial
  begin
    {cyc, stb, we, frame, adr, sel, dat_w} = '0;
  end

  // One classic cycle, held until ack
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] q);
    @(posedge clk);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    sel   <= s;
    dat_w <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = dat_r;
    cyc   <= 1'b0;
    stb   <= 1'b0;
    dat_w <= ~d;
  endtask : xfer

  // One frame start pulse, then let gains settle
  task automatic pulse_frame();
    @(posedge clk);
    frame <= 1'b1;
    @(posedge clk);
    frame <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : pulse_frame
endmodule : scx_host_model

// ==== scx_pkg.sv ====
// Constants, register map and types of the context switch configuration block
package scx_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int NSET      = 25;
  localparam int CTX_DEPTH = 256;
  localparam int CTX_W     = 16;

  // ************************************************************
  // Switchable setting indices within one set
  // ************************************************************
  localparam int S_EXP_ROWS        = 0;
  localparam int S_LINE_LEN        = 1;
  localparam int S_FRAME_LEN       = 2;
  localparam int S_ROW_BIN         = 3;
  localparam int S_COL_BIN         = 4;
  localparam int S_FINE_GAIN       = 5;
  localparam int S_COARSE_GAIN     = 6;
  localparam int S_EXP_ROWS_SECOND = 7;
  localparam int S_CG_OVR          = 8;
  localparam int S_CG_OVR_T1       = 9;
  localparam int S_PIX_COMB_BYP    = 10;
  localparam int S_COARSE_GAIN_T1  = 11;
  localparam int S_FINE_GAIN_T1    = 12;
  localparam int S_X_START         = 13;
  localparam int S_Y_START         = 14;
  localparam int S_X_END           = 15;
  localparam int S_Y_END           = 16;
  localparam int S_Y_ODD_INC       = 17;
  localparam int S_X_ODD_INC       = 18;
  localparam int S_GAIN_GR         = 19;
  localparam int S_GAIN_B          = 20;
  localparam int S_GAIN_R          = 21;
  localparam int S_GAIN_GB         = 22;
  localparam int S_GLOBAL_GAIN     = 23;
  localparam int S_OP_MODE         = 24;

  // ************************************************************
  // Register map (byte addresses) and fields
  // ************************************************************
  localparam logic [11:0] A_CTRL  = 12'h000;
  localparam logic [11:0] A_STAT  = 12'h004;
  localparam logic [11:0] A_BANKA = 12'h100;
  localparam logic [11:0] A_BANKB = 12'h200;
  localparam logic [11:0] A_CTXM  = 12'h400;
  localparam int CTRL_SEL    = 0;
  localparam int ST_EXP_SET  = 0;
  localparam int ST_OTH_SET  = 1;
  localparam int ST_FCNT_LSB = 16;
  localparam int OPM_HDR     = 0;
  localparam int RB_BIN      = 0;
  localparam int RB_SUM      = 1;

  // ************************************************************
  // Variants, gain limits and reset values
  // ************************************************************
  localparam int VAR_COLOUR = 0;
  localparam int VAR_MONO   = 1;
  localparam int VAR_RGBIR  = 2;
  localparam logic [2:0]  AG_COARSE_MAX = 3'h4;
  localparam logic [15:0] DG_UNITY      = 16'h0080;
  localparam logic [15:0] DG_MAX        = 16'h0800;
  localparam logic [15:0] SKIP2_INC     = 16'h0003;
  localparam logic [15:0] RST_LINE_LEN  = 16'h0400;
  localparam logic [15:0] RST_FRAME_LEN = 16'h0460;
  localparam logic [15:0] RST_X_END     = 16'h0787;
  localparam logic [15:0] RST_Y_END     = 16'h043f;
  localparam logic [15:0] RST_EXP_ROWS  = 16'h0010;
  localparam logic [15:0] RST_ODD_INC   = 16'h0001;

  typedef enum logic {WB_IDLE, WB_MEMRD} scx_wb_e;

  function automatic logic [15:0] setting_rst(input int i);
    unique case (i)
      S_LINE_LEN:                    return RST_LINE_LEN;
      S_FRAME_LEN:                   return RST_FRAME_LEN;
      S_X_END:                       return RST_X_END;
      S_Y_END:                       return RST_Y_END;
      S_EXP_ROWS, S_EXP_ROWS_SECOND: return RST_EXP_ROWS;
      S_X_ODD_INC, S_Y_ODD_INC:      return RST_ODD_INC;
      S_GAIN_GR, S_GAIN_B, S_GAIN_R,
      S_GAIN_GB, S_GLOBAL_GAIN:      return DG_UNITY;
      default:                       return 16'h0000;
    endcase
  endfunction : setting_rst

endpackage : scx_pkg

// ==== scx_readout.sv ====
// Readout controls derived from the active settings snapshot
`timescale 1ns/1ns
module scx_readout
  import scx_pkg::*;
#(
  parameter int VARIANT = VAR_COLOUR
)(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Active settings
  input  wire logic [NSET-1:0][15:0] act,
  // Gains
  output logic      [6:0]            ag,
  output logic      [6:0]            ag_t1,
  output logic      [15:0]           dg_r,
  output logic      [15:0]           dg_gr,
  output logic      [15:0]           dg_gb,
  output logic      [15:0]           dg_b,
  output logic      [15:0]           dg_global,
  // Subsampling and mode
  output logic                       h_bin,
  output logic                       v_bin,
  output logic                       v_sum,
  output logic                       x_skip,
  output logic                       y_skip,
  output logic      [15:0]           rows_out,
  output logic                       hdr_il
);

  typedef struct packed {
    logic [6:0]  ag;
    logic [6:0]  ag_t1;
    logic [15:0] dg_r;
    logic [15:0] dg_gr;
    logic [15:0] dg_gb;
    logic [15:0] dg_b;
    logic [15:0] dg_global;
    logic        h_bin;
    logic        v_bin;
    logic        v_sum;
    logic        x_skip;
    logic        y_skip;
    logic [15:0] rows_out;
    logic        hdr_il;
  } scx_ro_s;

  scx_ro_s r_reg;
  scx_ro_s r_next;

  // Analog gain code: coarse doubles, capped at x16
  function automatic logic [6:0] ag_code(input logic [15:0] c,
                                         input logic [15:0] f);
    if (c[2:0] >= AG_COARSE_MAX) return {AG_COARSE_MAX, 4'h0};
    return {c[2:0], f[3:0]};
  endfunction : ag_code

  function automatic logic [15:0] dg_clamp(input logic [15:0] g);
    if (g < DG_UNITY) return DG_UNITY;
    if (g > DG_MAX)   return DG_MAX;
    return g;
  endfunction : dg_clamp

  always_comb
  begin
    r_next           = r_reg;
    r_next.hdr_il    = act[S_OP_MODE][OPM_HDR];
    r_next.ag        = ag_code(act[S_COARSE_GAIN],
                               act[S_FINE_GAIN]);
    r_next.ag_t1     = r_next.hdr_il ?
                       ag_code(act[S_COARSE_GAIN_T1],
                               act[S_FINE_GAIN_T1]) : r_next.ag;
    r_next.dg_r      = dg_clamp(act[S_GAIN_R]);
    r_next.dg_gr     = dg_clamp(act[S_GAIN_GR]);
    r_next.dg_gb     = dg_clamp(act[S_GAIN_GB]);
    r_next.dg_b      = dg_clamp(act[S_GAIN_B]);
    r_next.dg_global = dg_clamp(act[S_GLOBAL_GAIN]);
    r_next.h_bin     = (VARIANT != VAR_RGBIR)
                       && act[S_COL_BIN][RB_BIN];
    r_next.v_bin     = (VARIANT != VAR_RGBIR)
                       && act[S_ROW_BIN][RB_BIN];
    r_next.v_sum     = (VARIANT == VAR_MONO)
                       && act[S_ROW_BIN][RB_SUM];
    r_next.x_skip    = act[S_X_ODD_INC] >= SKIP2_INC;
    r_next.y_skip    = act[S_Y_ODD_INC] >= SKIP2_INC;
    r_next.rows_out  = 16'(act[S_Y_END] - act[S_Y_START] + 16'h0001)
                       >> r_next.y_skip;
  end

  always_ff @(posedge clk)
  begin
    if (rst) r_reg <= '0;
    else     r_reg <= r_next;
  end

  assign ag        = r_reg.ag;
  assign ag_t1     = r_reg.ag_t1;
  assign dg_r      = r_reg.dg_r;
  assign dg_gr     = r_reg.dg_gr;
  assign dg_gb     = r_reg.dg_gb;
  assign dg_b      = r_reg.dg_b;
  assign dg_global = r_reg.dg_global;
  assign h_bin     = r_reg.h_bin;
  assign v_bin     = r_reg.v_bin;
  assign v_sum     = r_reg.v_sum;
  assign x_skip    = r_reg.x_skip;
  assign y_skip    = r_reg.y_skip;
  assign rows_out  = r_reg.rows_out;
  assign hdr_il    = r_reg.hdr_il;

endmodule : scx_readout
